// *** hw/mccfg_defines.vh ***
`ifndef MCCFG_DEFINES_VH
`define MCCFG_DEFINES_VH

// Register offsets (word index on the serial link)
`define MCCFG_ADDR_DRIVE_MODE   7'h00
`define MCCFG_ADDR_COMM_OFFSET  7'h01
`define MCCFG_ADDR_LOCK_CRIT    7'h02
`define MCCFG_ADDR_TOL_SCALE    7'h03
`define MCCFG_ADDR_COMM_CTRL    7'h04
`define MCCFG_NUM_REGS          5
`define MCCFG_LAST_IDX          3'h4

// Reset values (unprogrammed memory)
`define MCCFG_RESET_VALUE       16'h0000

// Writable bit masks; reserved bits read as zero
`define MCCFG_MASK_DRIVE_MODE   16'hFFFF
`define MCCFG_MASK_COMM_OFFSET  16'h00FF
`define MCCFG_MASK_LOCK_CRIT    16'hFFFF
`define MCCFG_MASK_TOL_SCALE    16'hFFFF
`define MCCFG_MASK_COMM_CTRL    16'h3FFF

// Field positions, drive_mode_config
`define MCCFG_SWITCH_RATE_HI    7
`define MCCFG_SWITCH_RATE_LO    6
`define MCCFG_SPEED_CMD_HI      5
`define MCCFG_SPEED_CMD_LO      4
`define MCCFG_FEEDBACK_HI       3
`define MCCFG_FEEDBACK_LO       2
`define MCCFG_STOP_BEHAV_BIT    1
`define MCCFG_RETRY_BIT         0
// commutation_offset
`define MCCFG_ADVANCE_HI        7
`define MCCFG_ADVANCE_LO        0
// lock_criteria
`define MCCFG_EXTRA_REVS_HI     15
`define MCCFG_EXTRA_REVS_LO     8
`define MCCFG_MAX_PERIOD_HI     7
`define MCCFG_MAX_PERIOD_LO     0
// tolerance_and_duty_scale
`define MCCFG_BASIC_BIT         15
`define MCCFG_TOLERANCE_HI      14
`define MCCFG_TOLERANCE_LO      12
`define MCCFG_DUTY_SCALE_HI     11
`define MCCFG_DUTY_SCALE_LO     0
// commutation_control
`define MCCFG_CNT_RST_HI        13
`define MCCFG_CNT_RST_LO        12
`define MCCFG_DELAY_BIT         11
`define MCCFG_AUTO_ADV_BIT      10
`define MCCFG_AUTO_GAIN_BIT     9

// Serial frame layout
`define MCCFG_FRAME_BITS        5'd24
`define MCCFG_HEADER_BITS       5'd8
`define MCCFG_FRAME_RW_BIT      7

// Timing
`define MCCFG_CLK_KHZ           250000
`define MCCFG_CLK_MHZ           250
`define MCCFG_PWM_RATE0_KHZ     25
`define MCCFG_PWM_RATE1_KHZ     50
`define MCCFG_PWM_RATE2_KHZ     100
`define MCCFG_PWM_RATE3_KHZ     200
`define MCCFG_LOCK_UNIT_US      2560
`define MCCFG_LOCK_UNIT_CYC     20'd640000
`define MCCFG_TOL_BASE_SHIFT    4'h9

`endif

// *** hw/mccfg_spi_slave.v ***
`timescale 1ns/1ps
`include "mccfg_defines.vh"

module mccfg_spi_slave (
    input  wire        sys_clk_in,
    input  wire        reset_in,
    input  wire        spi_sclk_in,
    input  wire        spi_cs_n_in,
    input  wire        spi_mosi_in,
    input  wire [15:0] rd_data_in,
    output wire [6:0]  addr_out,
    output wire        wr_pulse_out,
    output wire [15:0] wr_data_out,
    output wire        miso_out,
    output wire        miso_oe_out
);

    reg        sclk_prev_reg;
    reg [4:0]  bit_cnt_reg;
    reg [23:0] rx_reg;
    reg [15:0] tx_reg;
    reg        miso_reg;
    reg        oe_reg;
    reg        wr_reg;
    reg [6:0]  addr_reg;

    wire rise = spi_sclk_in & ~sclk_prev_reg;
    wire fall = ~spi_sclk_in & sclk_prev_reg;
    wire [23:0] rx_shift = {rx_reg[22:0], spi_mosi_in};

    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sclk_prev_reg <= 1'b0;
            bit_cnt_reg   <= 5'h00;
            rx_reg        <= 24'h00_0000;
            tx_reg        <= 16'h0000;
            miso_reg      <= 1'b0;
            oe_reg        <= 1'b0;
            wr_reg        <= 1'b0;
            addr_reg      <= 7'h00;
        end else begin
            sclk_prev_reg <= spi_sclk_in;
            wr_reg        <= 1'b0;
            oe_reg        <= ~spi_cs_n_in;
            if (spi_cs_n_in) begin
                bit_cnt_reg <= 5'h00;
                miso_reg    <= 1'b0;
            end else begin
                if (rise && bit_cnt_reg != `MCCFG_FRAME_BITS) begin
                    rx_reg      <= rx_shift;
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == `MCCFG_HEADER_BITS - 5'h01)
                        addr_reg <= rx_shift[6:0];
                    if (bit_cnt_reg == `MCCFG_FRAME_BITS - 5'h01)
                        wr_reg <= ~rx_shift[16 + `MCCFG_FRAME_RW_BIT];
                end
                if (bit_cnt_reg == `MCCFG_HEADER_BITS && rise == 1'b0 && fall == 1'b0
                    && sclk_prev_reg)
                    tx_reg <= rd_data_in;
                if (fall && bit_cnt_reg >= `MCCFG_HEADER_BITS) begin
                    miso_reg <= tx_reg[15];
                    tx_reg   <= {tx_reg[14:0], 1'b0};
                end
            end
        end
    end

    assign addr_out     = addr_reg;
    assign wr_pulse_out = wr_reg;
    assign wr_data_out  = rx_reg[15:0];
    assign miso_out     = miso_reg;
    assign miso_oe_out  = oe_reg;

endmodule // mccfg_spi_slave

// *** hw/mccfg_top.v ***
`timescale 1ns/1ps
`include "mccfg_defines.vh"

module mccfg_top #(
    parameter [19:0] LOCK_UNIT_CYCLES = `MCCFG_LOCK_UNIT_CYC
) (
    input  wire        sys_clk_in,
    input  wire        reset_in,
    input  wire        spi_sclk_in,
    input  wire        spi_cs_n_in,
    input  wire        spi_mosi_in,
    output wire        spi_miso_out,
    output wire        spi_miso_oe_out,
    input  wire        config_source_pin_in,
    output reg         nvm_req_out,
    output reg  [2:0]  nvm_addr_out,
    output reg         nvm_use_eeprom_out,
    input  wire [15:0] nvm_data_in,
    input  wire        nvm_valid_in,
    output reg         config_loaded_out,
    input  wire        hall_u_in,
    input  wire        hall_v_in,
    input  wire        hall_w_in,
    input  wire        frequency_feedback_amp_in,
    input  wire        tachometer_input_in,
    input  wire        enable_in,
    input  wire        fault_in,
    input  wire [11:0] duty_in,
    output reg  [13:0] switch_period_out,
    output reg  [1:0]  speed_cmd_source_out,
    output reg         speed_cmd_reserved_out,
    output reg         speed_feedback_out,
    output reg         phase_hiz_out,
    output reg         low_side_brake_out,
    output reg         drive_off_out,
    output reg  [7:0]  advance_count_out,
    output reg         advance_lag_out,
    output reg         three_hall_120_out,
    output reg         speed_locked_out,
    output reg  [11:0] scaled_duty_out,
    output reg         comm_counter_reset_out,
    output reg         auto_advance_en_out,
    output reg         auto_gain_en_out
);

    localparam [31:0] PER0 = `MCCFG_CLK_KHZ / `MCCFG_PWM_RATE0_KHZ;
    localparam [31:0] PER1 = `MCCFG_CLK_KHZ / `MCCFG_PWM_RATE1_KHZ;
    localparam [31:0] PER2 = `MCCFG_CLK_KHZ / `MCCFG_PWM_RATE2_KHZ;
    localparam [31:0] PER3 = `MCCFG_CLK_KHZ / `MCCFG_PWM_RATE3_KHZ;

    localparam [1:0] LD_REQ  = 2'h0;
    localparam [1:0] LD_WAIT = 2'h1;
    localparam [1:0] LD_DONE = 2'h2;

    reg  [15:0] cfg_reg [0:`MCCFG_NUM_REGS-1];
    reg  [1:0]  ld_state_reg;
    reg  [1:0]  ld_state_next;
    reg         ld_write;
    reg  [15:0] rd_data;

    wire [6:0]  spi_addr;
    wire        spi_wr;
    wire [15:0] spi_wdata;

    mccfg_spi_slave u_spi (
        .sys_clk_in   (sys_clk_in),
        .reset_in     (reset_in),
        .spi_sclk_in  (spi_sclk_in),
        .spi_cs_n_in  (spi_cs_n_in),
        .spi_mosi_in  (spi_mosi_in),
        .rd_data_in   (rd_data),
        .addr_out     (spi_addr),
        .wr_pulse_out (spi_wr),
        .wr_data_out  (spi_wdata),
        .miso_out     (spi_miso_out),
        .miso_oe_out  (spi_miso_oe_out)
    );

    function [15:0] reg_mask;
        input [2:0] idx;
        begin
            case (idx)
                3'h0:    reg_mask = `MCCFG_MASK_DRIVE_MODE;
                3'h1:    reg_mask = `MCCFG_MASK_COMM_OFFSET;
                3'h2:    reg_mask = `MCCFG_MASK_LOCK_CRIT;
                3'h3:    reg_mask = `MCCFG_MASK_TOL_SCALE;
                3'h4:    reg_mask = `MCCFG_MASK_COMM_CTRL;
                default: reg_mask = 16'h0000;
            endcase
        end
    endfunction

    // Register storage; a serial write wins over a memory load
    genvar gi;
    generate
        for (gi = 0; gi < `MCCFG_NUM_REGS; gi = gi + 1) begin : g_reg
            always @(posedge sys_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    cfg_reg[gi] <= `MCCFG_RESET_VALUE;
                end else if (spi_wr && spi_addr == gi) begin
                    cfg_reg[gi] <= spi_wdata & reg_mask(gi);
                end else if (ld_write && nvm_addr_out == gi) begin
                    cfg_reg[gi] <= nvm_data_in & reg_mask(gi);
                end
            end
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    always @* begin
        rd_data = 16'h0000;
        if (spi_addr < `MCCFG_NUM_REGS)
            rd_data = cfg_reg[spi_addr[2:0]];
    end

    // Memory load sequence after reset
    always @* begin
        ld_state_next = ld_state_reg;
        ld_write      = 1'b0;
        case (ld_state_reg)
            LD_REQ:  ld_state_next = LD_WAIT;
            LD_WAIT: begin
                if (nvm_valid_in) begin
                    ld_write = 1'b1;
                    if (nvm_addr_out == `MCCFG_LAST_IDX)
                        ld_state_next = LD_DONE;
                    else
                        ld_state_next = LD_REQ;
                end
            end
            LD_DONE: ld_state_next = LD_DONE;
            default: ld_state_next = LD_DONE;
        endcase
    end

    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ld_state_reg       <= LD_REQ;
            nvm_req_out        <= 1'b0;
            nvm_addr_out       <= 3'h0;
            nvm_use_eeprom_out <= 1'b0;
            config_loaded_out  <= 1'b0;
        end else begin
            ld_state_reg      <= ld_state_next;
            nvm_req_out       <= (ld_state_next == LD_WAIT);
            config_loaded_out <= (ld_state_next == LD_DONE);
            if (ld_state_reg == LD_REQ && nvm_addr_out == 3'h0)
                nvm_use_eeprom_out <= config_source_pin_in;
            if (ld_write && nvm_addr_out != `MCCFG_LAST_IDX)
                nvm_addr_out <= nvm_addr_out + 3'h1;
        end
    end

    // Field views
    wire [1:0]  f_rate     = cfg_reg[0][`MCCFG_SWITCH_RATE_HI:`MCCFG_SWITCH_RATE_LO];
    wire [1:0]  f_cmd      = cfg_reg[0][`MCCFG_SPEED_CMD_HI:`MCCFG_SPEED_CMD_LO];
    wire [1:0]  f_fb       = cfg_reg[0][`MCCFG_FEEDBACK_HI:`MCCFG_FEEDBACK_LO];
    wire        f_stop     = cfg_reg[0][`MCCFG_STOP_BEHAV_BIT];
    wire        f_retry    = cfg_reg[0][`MCCFG_RETRY_BIT];
    wire [7:0]  f_adv      = cfg_reg[1][`MCCFG_ADVANCE_HI:`MCCFG_ADVANCE_LO];
    wire [7:0]  f_revs     = cfg_reg[2][`MCCFG_EXTRA_REVS_HI:`MCCFG_EXTRA_REVS_LO];
    wire [7:0]  f_maxper   = cfg_reg[2][`MCCFG_MAX_PERIOD_HI:`MCCFG_MAX_PERIOD_LO];
    wire        f_basic    = cfg_reg[3][`MCCFG_BASIC_BIT];
    wire [2:0]  f_tol      = cfg_reg[3][`MCCFG_TOLERANCE_HI:`MCCFG_TOLERANCE_LO];
    wire [11:0] f_scale    = cfg_reg[3][`MCCFG_DUTY_SCALE_HI:`MCCFG_DUTY_SCALE_LO];
    wire [1:0]  f_cnt_rst  = cfg_reg[4][`MCCFG_CNT_RST_HI:`MCCFG_CNT_RST_LO];
    wire        f_delay    = cfg_reg[4][`MCCFG_DELAY_BIT];
    wire        f_auto_adv = cfg_reg[4][`MCCFG_AUTO_ADV_BIT];
    wire        f_auto_gn  = cfg_reg[4][`MCCFG_AUTO_GAIN_BIT];

    // Hall period measurement and lock
    reg         hall_prev_reg;
    reg  [27:0] per_cnt_reg;
    reg  [27:0] last_per_reg;
    reg  [7:0]  rev_cnt_reg;
    reg  [2:0]  edge_cnt_reg;
    reg         fault_latch_reg;
    wire        hall_edge = hall_u_in & ~hall_prev_reg;
    wire [27:0] max_lim   = f_maxper * LOCK_UNIT_CYCLES;
    wire [3:0]  tol_shift = `MCCFG_TOL_BASE_SHIFT - {1'b0, f_tol};
    wire [27:0] tol_lim   = per_cnt_reg >> tol_shift;
    wire [27:0] per_diff  = (per_cnt_reg > last_per_reg) ? per_cnt_reg - last_per_reg
                                                         : last_per_reg - per_cnt_reg;
    wire        crit_ok   = (per_cnt_reg <= max_lim) && (per_diff <= tol_lim)
                            && (last_per_reg != 28'h000_0000);
    wire [2:0]  rst_mask  = (3'h1 << f_cnt_rst) - 3'h1;
    wire [23:0] duty_prod = duty_in * f_scale;
    wire        drive_off = fault_latch_reg | fault_in;

    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            hall_prev_reg          <= 1'b0;
            per_cnt_reg            <= 28'h000_0000;
            last_per_reg           <= 28'h000_0000;
            rev_cnt_reg            <= 8'h00;
            edge_cnt_reg           <= 3'h0;
            fault_latch_reg        <= 1'b0;
            speed_locked_out       <= 1'b0;
            comm_counter_reset_out <= 1'b0;
        end else begin
            hall_prev_reg          <= hall_u_in;
            comm_counter_reset_out <= 1'b0;
            if (!f_retry && fault_in)
                fault_latch_reg <= 1'b1;
            if (hall_edge) begin
                per_cnt_reg  <= 28'h000_0001;
                last_per_reg <= per_cnt_reg;
                edge_cnt_reg <= edge_cnt_reg + 3'h1;
                comm_counter_reset_out <= ((edge_cnt_reg & rst_mask) == 3'h0);
                if (crit_ok) begin
                    if (rev_cnt_reg >= f_revs)
                        speed_locked_out <= 1'b1;
                    else
                        rev_cnt_reg <= rev_cnt_reg + 8'h01;
                end else begin
                    rev_cnt_reg      <= 8'h00;
                    speed_locked_out <= 1'b0;
                end
            end else if (per_cnt_reg != 28'hFFF_FFFF) begin
                per_cnt_reg <= per_cnt_reg + 28'h000_0001;
                if (per_cnt_reg > max_lim)
                    speed_locked_out <= 1'b0;
            end
        end
    end

    // Decoded configuration outputs
    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            switch_period_out      <= 14'h0000;
            speed_cmd_source_out   <= 2'h0;
            speed_cmd_reserved_out <= 1'b0;
            speed_feedback_out     <= 1'b0;
            phase_hiz_out          <= 1'b1;
            low_side_brake_out     <= 1'b0;
            drive_off_out          <= 1'b0;
            advance_count_out      <= 8'h00;
            advance_lag_out        <= 1'b0;
            three_hall_120_out     <= 1'b0;
            scaled_duty_out        <= 12'h000;
            auto_advance_en_out    <= 1'b0;
            auto_gain_en_out       <= 1'b0;
        end else begin
            case (f_rate)
                2'h0:    switch_period_out <= PER0[13:0];
                2'h1:    switch_period_out <= PER1[13:0];
                2'h2:    switch_period_out <= PER2[13:0];
                default: switch_period_out <= PER3[13:0];
            endcase
            speed_cmd_source_out   <= f_cmd;
            speed_cmd_reserved_out <= (f_cmd == 2'h3);
            case (f_fb)
                2'h0:    speed_feedback_out <= hall_u_in;
                2'h1:    speed_feedback_out <= hall_u_in ^ hall_v_in ^ hall_w_in;
                2'h2:    speed_feedback_out <= frequency_feedback_amp_in;
                default: speed_feedback_out <= tachometer_input_in;
            endcase
            drive_off_out      <= drive_off;
            phase_hiz_out      <= drive_off | (~enable_in & ~f_stop);
            low_side_brake_out <= ~drive_off & ~enable_in & f_stop;
            advance_count_out  <= f_basic ? 8'h00 : f_adv;
            advance_lag_out    <= f_delay;
            three_hall_120_out <= f_basic;
            if (f_cmd == 2'h1)
                scaled_duty_out <= duty_prod[23:12];
            else
                scaled_duty_out <= duty_in;
            auto_advance_en_out <= f_auto_adv;
            auto_gain_en_out    <= f_auto_gn;
        end
    end

endmodule // mccfg_top

// *** bench/mccfg_top_props.sv ***
`timescale 1ns/1ps
module mccfg_top_props (
    input wire        sys_clk_in,
    input wire        reset_in,
    input wire        spi_cs_n_in,
    input wire        spi_miso_oe_out,
    input wire        nvm_req_out,
    input wire [2:0]  nvm_addr_out,
    input wire        nvm_valid_in,
    input wire        config_loaded_out,
    input wire        fault_in,
    input wire        drive_off_out,
    input wire        phase_hiz_out,
    input wire        low_side_brake_out,
    input wire [13:0] switch_period_out,
    input wire [1:0]  speed_cmd_source_out,
    input wire        speed_cmd_reserved_out,
    input wire [7:0]  advance_count_out,
    input wire        three_hall_120_out,
    input wire        comm_counter_reset_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    period_legal_a: assert property (!$past(reset_in) |-> switch_period_out inside
        {14'd10000, 14'd5000, 14'd2500, 14'd1250}) else $error("switch period illegal");
    reserved_cmd_a: assert property (speed_cmd_reserved_out ==
        (speed_cmd_source_out == 2'b11)) else $error("reserved command flag wrong");
    stop_excl_a: assert property (!(phase_hiz_out && low_side_brake_out))
        else $error("high impedance and brake together");
    fault_off_a: assert property (fault_in |=> drive_off_out)
        else $error("fault did not turn drive off");
    basic_advance_a: assert property (three_hall_120_out |-> advance_count_out == 8'h00)
        else $error("advance not forced to zero");
    reset_pulse_a: assert property (comm_counter_reset_out |=> !comm_counter_reset_out)
        else $error("counter reset pulse too long");
    oe_follow_a: assert property (!$past(reset_in) |->
        spi_miso_oe_out == !$past(spi_cs_n_in)) else $error("output enable not following select");
    nvm_drop_a: assert property (nvm_req_out && nvm_valid_in |=> !nvm_req_out)
        else $error("memory request held after word");
    load_done_a: assert property (nvm_req_out && nvm_valid_in &&
        nvm_addr_out == 3'h4 |=> config_loaded_out) else $error("load not marked done");
    cover property ($rose(config_loaded_out));
    cover property ($rose(low_side_brake_out));
    cover property (comm_counter_reset_out);
endmodule // mccfg_top_props
bind mccfg_top mccfg_top_props mccfg_top_props_inst (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .spi_cs_n_in(spi_cs_n_in),
    .spi_miso_oe_out(spi_miso_oe_out), .nvm_req_out(nvm_req_out), .nvm_addr_out(nvm_addr_out),
    .nvm_valid_in(nvm_valid_in), .config_loaded_out(config_loaded_out), .fault_in(fault_in),
    .drive_off_out(drive_off_out), .phase_hiz_out(phase_hiz_out),
    .low_side_brake_out(low_side_brake_out), .switch_period_out(switch_period_out),
    .speed_cmd_source_out(speed_cmd_source_out),
    .speed_cmd_reserved_out(speed_cmd_reserved_out), .advance_count_out(advance_count_out),
    .three_hall_120_out(three_hall_120_out), .comm_counter_reset_out(comm_counter_reset_out));

// *** bench/mccfg_far_model.sv ***
`timescale 1ns/1ps
module mccfg_far_model (
    input  wire        clk_in,
    input  wire        miso_in,
    input  wire        nvm_req_in,
    input  wire [2:0]  nvm_addr_in,
    output reg         sclk_out,
    output reg         cs_n_out,
    output reg         mosi_out,
    output reg  [15:0] nvm_data_out,
    output reg         nvm_valid_out
);
    reg [2:0] dly = 3'h0;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
        nvm_data_out = 16'h0000;
        nvm_valid_out = 1'b0;
    end
    // Stored word per index, reserved bits set on purpose
    function [15:0] word(input [2:0] n);
        word = 16'hc3a5 ^ {n, n, n, n, n, 1'b1};
    endfunction
    // Memory answers later for higher indices; data scrambles when not valid
    always @(posedge clk_in) begin
        nvm_valid_out <= 1'b0;
        nvm_data_out <= ~nvm_data_out;
        if (nvm_req_in && !nvm_valid_out) begin
            dly <= (dly == nvm_addr_in) ? 3'h0 : dly + 3'h1;
            if (dly == nvm_addr_in) begin
                nvm_valid_out <= 1'b1;
                nvm_data_out <= word(nvm_addr_in);
            end
        end
    end
    // Host frame: command bit, address, data, all MSB first
    task frame(input rw, input [6:0] a, input [15:0] d, output [15:0] q);
        reg     [23:0] f;
        integer        b;
        begin
            f = {rw, a, d};
            q = 16'h0000;
            @(negedge clk_in) cs_n_out = 1'b0;
            for (b = 23; b >= 0; b = b - 1) begin
                @(negedge clk_in) mosi_out = f[b];
                repeat (2) @(negedge clk_in);
                sclk_out = 1'b1;
                repeat (2) @(negedge clk_in);
                q = {q[14:0], miso_in};
                sclk_out = 1'b0;
            end
            repeat (4) @(negedge clk_in);
            cs_n_out = 1'b1;
            mosi_out = ~mosi_out;
            repeat (2) @(negedge clk_in);
        end
    endtask
endmodule // mccfg_far_model

// *** bench/mccfg_top_tb.sv ***
`timescale 1ns/1ps
module mccfg_top_tb;
    reg         sys_clk_in = 1'b0;
    reg         reset_in = 1'b1;
    reg         src_pin = 1'b0;
    reg         hu = 1'b0, hv = 1'b0, hw = 1'b0, fga = 1'b0, tachometer_input = 1'b0;
    reg         enable = 1'b1, fault = 1'b0;
    reg  [11:0] duty = 12'h000;
    reg  [15:0] q, d, e;
    reg  [6:0]  a;
    integer     i, c, k, r, checks, bad_count, pc = 0, cyc = 0;
    wire        sclk, cs_n, mosi, miso, req, vld, ee, loaded;
    wire        rsv, fb, hiz, brk, off, lag, b120, lock, crst, aa, ag;
    wire [2:0]  naddr;
    wire [15:0] ndata;
    wire [13:0] sp;
    wire [1:0]  src;
    wire [7:0]  adv;
    wire [11:0] sd;
    mccfg_top #(.LOCK_UNIT_CYCLES(20'd16)) mccfg_top_inst (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .spi_sclk_in(sclk),
        .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(),
        .config_source_pin_in(src_pin), .nvm_req_out(req), .nvm_addr_out(naddr),
        .nvm_use_eeprom_out(ee), .nvm_data_in(ndata), .nvm_valid_in(vld),
        .config_loaded_out(loaded), .hall_u_in(hu), .hall_v_in(hv), .hall_w_in(hw),
        .frequency_feedback_amp_in(fga), .tachometer_input_in(tachometer_input), .enable_in(enable),
        .fault_in(fault), .duty_in(duty), .switch_period_out(sp), .speed_cmd_source_out(src),
        .speed_cmd_reserved_out(rsv), .speed_feedback_out(fb), .phase_hiz_out(hiz),
        .low_side_brake_out(brk), .drive_off_out(off), .advance_count_out(adv),
        .advance_lag_out(lag), .three_hall_120_out(b120), .speed_locked_out(lock),
        .scaled_duty_out(sd), .comm_counter_reset_out(crst), .auto_advance_en_out(aa),
        .auto_gain_en_out(ag));
    mccfg_far_model far_inst (
        .clk_in(sys_clk_in), .miso_in(miso), .nvm_req_in(req), .nvm_addr_in(naddr),
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .nvm_data_out(ndata),
        .nvm_valid_out(vld));
    initial forever #2 sys_clk_in = ~sys_clk_in;
    task tick(input integer n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    task check(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d bad_count %0d", checks, bad_count);
            if (bad_count == 0 && checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task wr(input [6:0] wa, input [15:0] wd);
        begin
            far_inst.frame(1'b0, wa, wd, q);
            tick(4);
        end
    endtask
    task spin(input integer n, input integer h);
        repeat (n) begin
            hu = 1'b1;
            tick(h);
            hu = 1'b0;
            tick(h);
        end
    endtask
    task settle;
        begin
            k = 0;
            while (loaded !== 1'b1 && k < 200) begin
                tick(1);
                k = k + 1;
            end
            check("loaded", 16'(loaded), 16'h0001);
            tick(2);
        end
    endtask
    function [15:0] mask(input integer n);
        mask = (n == 1) ? 16'h00ff : (n == 4) ? 16'h3fff : 16'hffff;
    endfunction
    function fbx(input integer n);
        case (n)
            0: fbx = hu;
            1: fbx = hu ^ hv ^ hw;
            2: fbx = fga;
            default: fbx = tachometer_input;
        endcase
    endfunction
    // Cycle ceiling and counter reset pulse tally
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (crst === 1'b1)
            pc <= pc + 1;
        if (cyc == 40000) begin
            bad_count = bad_count + 1;
            print_verdict;
        end
    end
    initial begin
        r = $urandom(82336);
        checks = 0;
        bad_count = 0;
        src_pin = $urandom;
        tick(20);
        reset_in = 1'b0;
        settle;
        check("source", 16'(ee), 16'(src_pin));
        for (i = 0; i < 5; i = i + 1) begin
            far_inst.frame(1'b1, 7'(i), 16'h0000, q);
            check("load", q, far_inst.word(3'(i)) & mask(i));
        end
        for (i = 0; i < 12; i = i + 1) begin
            a = (i == 11) ? 7'h7f : 7'(i % 6);
            d = $urandom;
            far_inst.frame(1'b0, a, d, q);
            far_inst.frame(1'b1, a, 16'h0000, q);
            check("readback", q, (a < 7'd5) ? d & mask(a) : 16'h0000);
        end
        for (c = 0; c < 4; c = c + 1) begin
            {hu, hv, hw, fga, tachometer_input} = 5'($urandom);
            wr(0, 16'(c * 16'h0054));
            check("period", 16'(sp), 16'(250000 / (25 << c)));
            check("cmd_src", 16'(src), 16'(c));
            check("cmd_rsv", 16'(rsv), 16'(c == 3));
            check("feedback", 16'(fb), 16'(fbx(c)));
        end
        for (i = 0; i < 4; i = i + 1) begin
            d = $urandom;
            e = {i[1], 15'($urandom)};
            duty = $urandom;
            k = $urandom;
            wr(0, 16'(i[0]) << 4);
            wr(1, d);
            wr(3, e);
            wr(4, 16'(k));
            check("advance", 16'(adv), e[15] ? 16'h0000 : d & 16'h00ff);
            check("b120", 16'(b120), 16'(e[15]));
            check("lag", 16'(lag), 16'(k[11]));
            check("auto", 16'({aa, ag}), 16'(k[10:9]));
            check("duty", 16'(sd), i[0] ? 16'((24'(duty) * e[11:0]) >> 12) : 16'(duty));
        end
        hu = 1'b0;
        for (c = 0; c < 4; c = c + 1) begin
            wr(4, 16'(c) << 12);
            k = pc;
            spin(16, 20);
            tick(4);
            check("cnt_reset", 16'(pc - k), 16'(16 >> c));
        end
        wr(3, 16'h0000);
        wr(2, 16'h02ff);
        spin(3, 100);
        check("lock_early", 16'(lock), 16'h0000);
        spin(4, 100);
        check("lock_set", 16'(lock), 16'h0001);
        spin(2, 101);
        check("tol_tight", 16'(lock), 16'h0000);
        wr(3, 16'h7000);
        spin(6, 100);
        spin(2, 110);
        check("tol_wide", 16'(lock), 16'h0001);
        wr(2, 16'h0201);
        spin(1, 100);
        check("max_period", 16'(lock), 16'h0000);
        for (c = 1; c >= 0; c = c - 1) begin
            wr(0, 16'(c * 3));
            enable = 1'b0;
            tick(3);
            check("hiz", 16'(hiz), 16'(c == 0));
            check("brake", 16'(brk), 16'(c == 1));
            enable = 1'b1;
            fault = 1'b1;
            tick(3);
            check("fault_off", 16'(off), 16'h0001);
            fault = 1'b0;
            tick(3);
            check("fault_after", 16'(off), 16'(c == 0));
        end
        reset_in = 1'b1;
        tick(2);
        reset_in = 1'b0;
        settle;
        check("latch_clear", 16'(off), 16'h0000);
        print_verdict;
    end
endmodule // mccfg_top_tb
